// file: verilog/iofr_cfg.svh
// Purpose: constants of the input/output fault response bank
// Assumes: included by bare name from the design
// Notes: command codes, field layouts, reset values and timing
`ifndef IOFR_CFG_SVH
`define IOFR_CFG_SVH
`define IOFR_CMD_TURN_ON_INPUT_THRESHOLD 8'h35
`define IOFR_CMD_OC_ACTION 8'h47
`define IOFR_CMD_OV_LIMIT 8'h55
`define IOFR_CMD_OV_ACTION 8'h56
`define IOFR_MAN_W 11
`define IOFR_TURN_ON_INPUT_THRESHOLD_EXP 5'h1e
`define IOFR_OV_EXP 5'h00
`define IOFR_OV_ACTION_VAL 8'h00
`define IOFR_ACT_LATCH 8'hc0
`define IOFR_ACT_RETRY 8'hfa
`define IOFR_RST_OC_ACTION 8'hc0
`define IOFR_RST_TURN_ON_INPUT_THRESHOLD_MAN 11'h010
`define IOFR_RST_OV_MAN 11'h011
`define IOFR_RETRY_TIME_MS 20
`define IOFR_CLK_KHZ 200000
`define IOFR_RETRY_CYCLES (`IOFR_RETRY_TIME_MS * `IOFR_CLK_KHZ)
`endif

// file: verilog/iofr_pkg.sv
// Purpose: types of the input/output fault response bank
// Assumes: nothing beyond the constants header
// Notes: request and answer travel as packed structs
`default_nettype none
package iofr_pkg;
	typedef enum logic [3:0] {
		IOFR_RD_BYTE = 4'h1,
		IOFR_WR_BYTE = 4'h2,
		IOFR_RD_WORD = 4'h4,
		IOFR_WR_WORD = 4'h8
	} iofr_kind_t;
	typedef enum logic [3:0] {
		IOFR_OFF = 4'h1,
		IOFR_RUN = 4'h2,
		IOFR_LATCHED = 4'h4,
		IOFR_RETRY = 4'h8
	} iofr_chan_t;
	typedef struct packed {
		logic valid;
		iofr_kind_t kind;
		logic [7:0] code;
		logic [15:0] wdata;
	} iofr_req_t;
	typedef struct packed {
		logic valid;
		logic error;
		logic [15:0] rdata;
	} iofr_rsp_t;
	typedef struct packed {
		logic byteIoutOc;
		logic byteOther;
		logic wordIout;
		logic wordInput;
		logic ioutOcFault;
		logic vinOvFault;
	} iofr_status_t;
endpackage : iofr_pkg
`default_nettype wire

// file: verilog/iofr_fault_response.sv
// Purpose: fault policy and input thresholds for a two-channel controller
// Assumes: decoded bus commands, telemetry on the same clock
// Notes: enable pins are asynchronous and pass two flip-flops
// Notes on behaviour
// - Overcurrent action code: byte reads and byte writes only.
// - All four commands hold one value shared by both channels.
// - Overcurrent fault turns the faulted channel off and sets overcurrent status.
// - A fault pulls the alert line unless its mask bit is set.
// - Code C0h: stay off until enable toggles or bias power cycles.
// - Code FAh: stop faulted channel, retry after 20 ms, repeat.
// - No conversion before input voltage reaches turn-on threshold.
// - Turn-on threshold: word access, exponent fixed 11110b, 0.25 V step.
// - Overvoltage limit: word access, exponent 00000b, mantissa 0..2047.
// - Overvoltage action: byte reads only, whole byte read-only.
// - Overvoltage action fixed 00h: keep converting, still flag, alert.
// - Input overvoltage sets other, input and input overvoltage bits.
// - Overcurrent detected when channel current reaches its limit.
// - Undervoltage fault masked until input passed turn-on and enabled.
`default_nettype none
`include "iofr_cfg.svh"
module iofr_fault_response #(
	parameter int RETRY_CYCLES = `IOFR_RETRY_CYCLES,
	parameter int CNT_W = 22
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire iofr_pkg::iofr_req_t req,
	output iofr_pkg::iofr_rsp_t rsp,
	input wire logic [1:0] enablePin,
	input wire logic [1:0] onBit,
	input wire logic enableByPin,
	input wire logic [10:0] ioutA,
	input wire logic [10:0] ioutB,
	input wire logic [10:0] ocLimitA,
	input wire logic [10:0] ocLimitB,
	input wire logic [10:0] vinQuarterVolts,
	input wire logic maskIoutOc,
	input wire logic maskVinOv,
	input wire logic clearFaults,
	output logic [1:0] convertEnable,
	output iofr_pkg::iofr_status_t status,
	output logic uvFaultArmed,
	output logic alertLineN
);
	localparam int CH = 2;
	localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);

	if (CNT_W < 1 || CNT_W > 30 || RETRY_CYCLES < 1 ||
		RETRY_CYCLES >= (1 << CNT_W)) begin : g_bad_size
		$error("RETRY_CYCLES does not fit the retry counter");
	end

	logic [CH-1:0] pinSync1Reg, pinSync1Next, pinSync2Reg, pinSync2Next;
	logic [CH-1:0] chanEn, ocHit;
	logic vinOk, vinOver;
	iofr_pkg::iofr_chan_t chanReg [CH];
	iofr_pkg::iofr_chan_t chanNext [CH];
	logic [CNT_W-1:0] cntReg [CH];
	logic [CNT_W-1:0] cntNext [CH];
	logic [CH-1:0] ocEvent;
	logic [CH-1:0] convNext;

	// Enable pins come from outside and are synchronised first
	always_comb begin
		pinSync1Next = enablePin;
		pinSync2Next = pinSync1Reg;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinSync1Reg <= 2'h0;
			pinSync2Reg <= 2'h0;
		end else begin
			pinSync1Reg <= pinSync1Next;
			pinSync2Reg <= pinSync2Next;
		end
	end

	// Register bank, one copy shared by both channels
	logic [7:0] ocActReg, ocActNext;
	logic [10:0] vinOnReg, vinOnNext, ovManReg, ovManNext;
	iofr_pkg::iofr_rsp_t rspNext;

	always_comb begin
		ocActNext = ocActReg;
		vinOnNext = vinOnReg;
		ovManNext = ovManReg;
		rspNext = '0;
		rspNext.valid = req.valid;
		if (req.valid) begin
			case (req.code)
				`IOFR_CMD_OC_ACTION: begin
					if (req.kind == iofr_pkg::IOFR_RD_BYTE)
						rspNext.rdata = {8'h00, ocActReg};
					else if (req.kind == iofr_pkg::IOFR_WR_BYTE)
						ocActNext = req.wdata[7:0];
					else
						rspNext.error = 1'b1;
				end
				`IOFR_CMD_TURN_ON_INPUT_THRESHOLD: begin
					if (req.kind == iofr_pkg::IOFR_RD_WORD)
						rspNext.rdata = {`IOFR_TURN_ON_INPUT_THRESHOLD_EXP, vinOnReg};
					else if (req.kind == iofr_pkg::IOFR_WR_WORD)
						vinOnNext = req.wdata[10:0];
					else
						rspNext.error = 1'b1;
				end
				`IOFR_CMD_OV_LIMIT: begin
					if (req.kind == iofr_pkg::IOFR_RD_WORD)
						rspNext.rdata = {`IOFR_OV_EXP, ovManReg};
					else if (req.kind == iofr_pkg::IOFR_WR_WORD)
						ovManNext = req.wdata[10:0];
					else
						rspNext.error = 1'b1;
				end
				`IOFR_CMD_OV_ACTION: begin
					if (req.kind == iofr_pkg::IOFR_RD_BYTE)
						rspNext.rdata = {8'h00, `IOFR_OV_ACTION_VAL};
					else
						rspNext.error = 1'b1;
				end
				default: rspNext.error = 1'b1;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ocActReg <= `IOFR_RST_OC_ACTION;
			vinOnReg <= `IOFR_RST_TURN_ON_INPUT_THRESHOLD_MAN;
			ovManReg <= `IOFR_RST_OV_MAN;
			rsp <= '0;
		end else begin
			ocActReg <= ocActNext;
			vinOnReg <= vinOnNext;
			ovManReg <= ovManNext;
			rsp <= rspNext;
		end
	end

	// Input thresholds in quarter volts; the limit is in whole volts
	always_comb begin
		vinOk = vinQuarterVolts >= vinOnReg;
		vinOver = {2'h0, vinQuarterVolts} > {ovManReg, 2'h0};
		ocHit[0] = ioutA >= ocLimitA;
		ocHit[1] = ioutB >= ocLimitB;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Per-channel power sequencing and fault policy
	for (genvar i = 0; i < CH; i++) begin : g_chan
		always_comb begin
			chanEn[i] = enableByPin ? pinSync2Reg[i] : onBit[i];
			chanNext[i] = chanReg[i];
			cntNext[i] = '0;
			ocEvent[i] = 1'b0;
			case (chanReg[i])
				iofr_pkg::IOFR_OFF: begin
					if (chanEn[i] && vinOk)
						chanNext[i] = iofr_pkg::IOFR_RUN;
				end
				iofr_pkg::IOFR_RUN: begin
					// Input overvoltage does not stop conversion
					if (!chanEn[i])
						chanNext[i] = iofr_pkg::IOFR_OFF;
					else if (ocHit[i]) begin
						ocEvent[i] = 1'b1;
						if (ocActReg == `IOFR_ACT_RETRY)
							chanNext[i] = iofr_pkg::IOFR_RETRY;
						else
							chanNext[i] = iofr_pkg::IOFR_LATCHED;
					end
				end
				iofr_pkg::IOFR_LATCHED: begin
					if (!chanEn[i])
						chanNext[i] = iofr_pkg::IOFR_OFF;
				end
				iofr_pkg::IOFR_RETRY: begin
					if (!chanEn[i])
						chanNext[i] = iofr_pkg::IOFR_OFF;
					else if (cntReg[i] == RETRY_LAST)
						chanNext[i] = iofr_pkg::IOFR_OFF;
					else
						cntNext[i] = cntReg[i] + 1'b1;
				end
				default: chanNext[i] = iofr_pkg::IOFR_OFF;
			endcase
			convNext[i] = chanNext[i] == iofr_pkg::IOFR_RUN;
		end
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				chanReg[i] <= iofr_pkg::IOFR_OFF;
				cntReg[i] <= '0;
			end else begin
				chanReg[i] <= chanNext[i];
				cntReg[i] <= cntNext[i];
			end
		end

		oc_latch_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_RUN && chanEn[i] && ocHit[i]
			&& ocActReg != `IOFR_ACT_RETRY
			|=> chanReg[i] == iofr_pkg::IOFR_LATCHED && !convertEnable[i])
			else $error("overcurrent did not latch off");
		latch_hold_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_LATCHED && chanEn[i]
			|=> chanReg[i] == iofr_pkg::IOFR_LATCHED)
			else $error("latched channel restarted");
		retry_entry_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_RUN && chanEn[i] && ocHit[i]
			&& ocActReg == `IOFR_ACT_RETRY
			|=> chanReg[i] == iofr_pkg::IOFR_RETRY && cntReg[i] == '0)
			else $error("retry not entered");
		retry_wait_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_RETRY && chanEn[i]
			&& cntReg[i] != RETRY_LAST
			|=> chanReg[i] == iofr_pkg::IOFR_RETRY
			&& cntReg[i] == $past(cntReg[i]) + 1'b1)
			else $error("retry left early");
		retry_done_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_RETRY && chanEn[i]
			&& cntReg[i] == RETRY_LAST |=> chanReg[i] == iofr_pkg::IOFR_OFF)
			else $error("retry did not end on time");
		retry_clear_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_RETRY && !chanEn[i]
			|=> chanReg[i] == iofr_pkg::IOFR_OFF && cntReg[i] == '0)
			else $error("retry survived disable");
		no_start_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_OFF && !vinOk
			|=> !convertEnable[i])
			else $error("started below turn-on");
		ov_ignore_a: assert property (
			chanReg[i] == iofr_pkg::IOFR_RUN && chanEn[i] && !ocHit[i]
			&& vinOver |=> convertEnable[i])
			else $error("overvoltage stopped conversion");
	end

	// Sticky status and alert; a set in the clear cycle wins
	logic ioutOcReg, ioutOcNext, vinOvReg, vinOvNext;
	logic armedNext, alertNext;
	iofr_pkg::iofr_status_t statusNext;
	always_comb begin
		ioutOcNext = (ioutOcReg && !clearFaults) || (|ocEvent);
		vinOvNext = (vinOvReg && !clearFaults) || vinOver;
		statusNext.byteIoutOc = ioutOcNext;
		statusNext.wordIout = ioutOcNext;
		statusNext.ioutOcFault = ioutOcNext;
		statusNext.byteOther = vinOvNext;
		statusNext.wordInput = vinOvNext;
		statusNext.vinOvFault = vinOvNext;
		alertNext = !((ioutOcNext && !maskIoutOc) ||
			(vinOvNext && !maskVinOv));
		armedNext = uvFaultArmed || (vinOk && (|chanEn));
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ioutOcReg <= 1'b0;
			vinOvReg <= 1'b0;
			status <= '0;
			alertLineN <= 1'b1;
			uvFaultArmed <= 1'b0;
			convertEnable <= 2'h0;
		end else begin
			ioutOcReg <= ioutOcNext;
			vinOvReg <= vinOvNext;
			status <= statusNext;
			alertLineN <= alertNext;
			uvFaultArmed <= armedNext;
			convertEnable <= convNext;
		end
	end

	ov_status_a: assert property (
		vinOver |=> status.byteOther && status.wordInput && status.vinOvFault)
		else $error("overvoltage status missing");
	oc_status_a: assert property (
		|ocEvent |=> status.byteIoutOc && status.wordIout &&
		status.ioutOcFault && (!$past(ocEvent[0]) || !convertEnable[0]) &&
		(!$past(ocEvent[1]) || !convertEnable[1]))
		else $error("overcurrent status missing");
	alert_raise_a: assert property (
		vinOver && !maskVinOv |=> !alertLineN)
		else $error("alert not raised");
	alert_oc_a: assert property (
		|ocEvent && !maskIoutOc |=> !alertLineN)
		else $error("overcurrent alert not raised");
	alert_mask_a: assert property (
		!ioutOcNext && !vinOvNext |=> alertLineN)
		else $error("alert without fault");
	ov_clear_a: assert property (
		clearFaults && vinOver |=> status.vinOvFault)
		else $error("clear beat a new overvoltage");
	oc_clear_a: assert property (
		clearFaults && !(|ocEvent) |=> !status.ioutOcFault)
		else $error("overcurrent status not cleared");
	byte_only_a: assert property (
		req.valid && req.code == `IOFR_CMD_OC_ACTION &&
		(req.kind == iofr_pkg::IOFR_RD_WORD ||
		req.kind == iofr_pkg::IOFR_WR_WORD) |=> rsp.valid && rsp.error)
		else $error("word access to byte command");
	turn_on_input_threshold_exp_a: assert property (
		req.valid && req.code == `IOFR_CMD_TURN_ON_INPUT_THRESHOLD &&
		req.kind == iofr_pkg::IOFR_RD_WORD
		|=> rsp.rdata[15:11] == `IOFR_TURN_ON_INPUT_THRESHOLD_EXP && !rsp.error)
		else $error("turn-on exponent wrong");
	ov_ro_a: assert property (
		req.valid && req.code == `IOFR_CMD_OV_ACTION &&
		req.kind != iofr_pkg::IOFR_RD_BYTE |=> rsp.error)
		else $error("overvoltage action accepted");
	rsp_pulse_a: assert property (
		!req.valid |=> !rsp.valid)
		else $error("answer without request");
	armed_hold_a: assert property (
		uvFaultArmed |=> uvFaultArmed)
		else $error("undervoltage arming lost");
endmodule : iofr_fault_response
`default_nettype wire

// file: verif/iofr_host.sv
// Purpose: command-port host model for the fault response bank
// Assumes: one request per call, answer registered on the edge that takes it
// Notes: drives 1 ns after the edge, holds request for one edge
`default_nettype none
module iofr_host (
	input wire logic clk,
	output iofr_pkg::iofr_req_t req,
	input wire iofr_pkg::iofr_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req = '0;
	// Callers may send kinds a code does not allow and unlisted codes
	task automatic xfer(input logic [3:0] k, input logic [7:0] c,
		input logic [15:0] w, output iofr_pkg::iofr_rsp_t r);
		@(posedge clk);
		#1 req = {1'b1, iofr_pkg::iofr_kind_t'(k), c, w};
		@(posedge clk);
		#1 req = '0;
		r = rsp;
	endtask : xfer
endmodule : iofr_host
`default_nettype wire

// file: verif/input_output_fault_response_tb.sv
// Purpose: self-checking bench of the fault response bank
// Assumes: short retry count of 8 cycles
// Notes: inputs change 1 ns after the rising edge
`default_nettype none
module input_output_fault_response_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [3:0] RB = 4'h1, WB = 4'h2, RW = 4'h4, WW = 4'h8;
	localparam logic [1:0] OK = 2'b10, ER = 2'b11;
	logic clk, rst_n, enableByPin, maskIoutOc, maskVinOv, clearFaults;
	logic [1:0] enablePin, onBit, convertEnable;
	logic [10:0] ioutA, ioutB, ocLimitA, ocLimitB, vinQv;
	logic uvFaultArmed, alertLineN;
	iofr_pkg::iofr_req_t req;
	iofr_pkg::iofr_rsp_t rsp;
	iofr_pkg::iofr_status_t status;
	int err_total, total_checks;
	iofr_fault_response #(.RETRY_CYCLES(8), .CNT_W(22)) dut (
		.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
		.enablePin(enablePin), .onBit(onBit), .enableByPin(enableByPin),
		.ioutA(ioutA), .ioutB(ioutB), .ocLimitA(ocLimitA),
		.ocLimitB(ocLimitB), .vinQuarterVolts(vinQv),
		.maskIoutOc(maskIoutOc), .maskVinOv(maskVinOv),
		.clearFaults(clearFaults), .convertEnable(convertEnable),
		.status(status), .uvFaultArmed(uvFaultArmed),
		.alertLineN(alertLineN)
	);
	iofr_host u_host (.clk(clk), .req(req), .rsp(rsp));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic bus(input logic [3:0] k, input logic [7:0] c,
		input logic [15:0] w, input logic [17:0] exp);
		iofr_pkg::iofr_rsp_t r;
		u_host.xfer(k, c, w, r);
		chk(r, exp);
	endtask : bus
	task automatic waitce(input logic [1:0] e);
		for (int i = 0; i < 20 && convertEnable !== e; i++) cyc(1);
		chk(convertEnable, e);
	endtask : waitce
	task automatic t_regs;
		bus(RB, 8'h47, 16'h0000, {OK, 16'h00c0});
		bus(RW, 8'h47, 16'h0000, {ER, 16'h0000});
		bus(RW, 8'h35, 16'h0000, {OK, 16'hf010});
		bus(RB, 8'h35, 16'h0000, {ER, 16'h0000});
		bus(RW, 8'h55, 16'h0000, {OK, 16'h0011});
		bus(RB, 8'h56, 16'h0000, {OK, 16'h0000});
		bus(WB, 8'h56, 16'h005a, {ER, 16'h0000});
		bus(RB, 8'h56, 16'h0000, {OK, 16'h0000});
		bus(WW, 8'h35, 16'h002d, {OK, 16'h0000});
		bus(RW, 8'h35, 16'h0000, {OK, 16'hf02d});
		bus(WW, 8'h55, 16'h000f, {OK, 16'h0000});
		bus(RW, 8'h55, 16'h0000, {OK, 16'h000f});
		bus(RB, 8'h99, 16'h0000, {ER, 16'h0000});
	endtask : t_regs
	task automatic t_vinon;
		vinQv = 11'd44;
		enablePin = 2'b11;
		cyc(10);
		chk(convertEnable, 2'b00);
		chk(uvFaultArmed, 1'b0);
		vinQv = 11'd45;
		waitce(2'b11);
		cyc(2);
		chk(uvFaultArmed, 1'b1);
	endtask : t_vinon
	task automatic t_latch;
		ioutA = 11'd100;
		waitce(2'b10);
		chk(status, 6'b101010);
		chk(alertLineN, 1'b0);
		ioutA = 11'd10;
		cyc(30);
		chk(convertEnable, 2'b10);
		enablePin = 2'b10;
		cyc(5);
		enablePin = 2'b11;
		waitce(2'b11);
		clearFaults = 1;
		cyc(1);
		clearFaults = 0;
		cyc(1);
		chk(alertLineN, 1'b1);
		chk(status, 6'b000000);
	endtask : t_latch
	task automatic t_retry;
		bus(WB, 8'h47, 16'h00fa, {OK, 16'h0000});
		maskIoutOc = 1;
		ioutB = 11'd100;
		waitce(2'b01);
		chk(status, 6'b101010);
		chk(alertLineN, 1'b1);
		ioutB = 11'd10;
		cyc(7);
		chk(convertEnable, 2'b01);
		cyc(2);
		chk(convertEnable, 2'b11);
		ioutB = 11'd100;
		waitce(2'b01);
		enablePin = 2'b01;
		ioutB = 11'd10;
		cyc(3);
		chk(convertEnable, 2'b01);
		enablePin = 2'b11;
		cyc(3);
		chk(convertEnable, 2'b11);
		clearFaults = 1;
		cyc(1);
		clearFaults = 0;
		maskIoutOc = 0;
	endtask : t_retry
	task automatic t_ov;
		vinQv = 11'd61;
		cyc(5);
		chk(status, 6'b010101);
		chk(alertLineN, 1'b0);
		chk(convertEnable, 2'b11);
		clearFaults = 1;
		cyc(1);
		clearFaults = 0;
		chk(status, 6'b010101);
		maskVinOv = 1;
		cyc(2);
		chk(alertLineN, 1'b1);
	endtask : t_ov
	task automatic t_rst;
		ioutA = 11'd100;
		waitce(2'b10);
		rst_n = 0;
		cyc(2);
		chk(convertEnable, 2'b00);
		chk(status, 6'b000000);
		chk(alertLineN, 1'b1);
		rst_n = 1;
		ioutA = 11'd10;
		bus(RB, 8'h47, 16'h0000, {OK, 16'h00c0});
		waitce(2'b11);
		enableByPin = 0;
		onBit = 2'b01;
		cyc(2);
		chk(convertEnable, 2'b01);
	endtask : t_rst
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial begin
		err_total = 0;
		total_checks = 0;
		rst_n = 0;
		enablePin = 2'b00;
		onBit = 2'b00;
		enableByPin = 1;
		{ioutA, ioutB} = {11'd10, 11'd10};
		{ocLimitA, ocLimitB} = {11'd100, 11'd100};
		vinQv = 11'd0;
		{maskIoutOc, maskVinOv, clearFaults} = 3'b000;
		repeat (20) @(posedge clk);
		#1 rst_n = 1;
		t_regs();
		t_vinon();
		t_latch();
		t_retry();
		t_ov();
		t_rst();
		report_and_stop();
	end
endmodule : input_output_fault_response_tb
`default_nettype wire
